//--- mqfep_top.sv
// four-queue flow-control buffer: queue select, flags, echo strobe, output register, power down
// assumes both hosts run on CLK; only the power-down pin is asynchronous
`include "mqfep_params.svh"

module mqfep_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WRITE_PORT_SELECT_N,
    input wire logic WRITE_ENABLE_N,
    input wire logic [`MQFEP_QSEL_W-1:0] WRITE_QUEUE_SELECT,
    input wire logic [`MQFEP_DATA_W-1:0] DATA_IN,
    input wire logic READ_PORT_SELECT_N,
    input wire logic READ_ENABLE_N,
    input wire logic [`MQFEP_QSEL_W-1:0] READ_QUEUE_SELECT,
    input wire logic OUTPUT_DRIVE_N,
    input wire logic FALL_THROUGH_MODE,
    input wire logic OUTPUT_WIDTH_SELECT,
    input wire logic POWER_DOWN_N,
    output logic [`MQFEP_DATA_W-1:0] DATA_OUT,
    output logic [1:0] DATA_OE_N,
    output logic ECHO_READ_STROBE_N,
    output logic [`MQFEP_QUEUES-1:0] FULL_FLAG_N,
    output logic [`MQFEP_QUEUES-1:0] EMPTY_FLAG_N,
    output logic [`MQFEP_QUEUES-1:0] ALMOST_FULL_FLAG_N,
    output logic [`MQFEP_QUEUES-1:0] ALMOST_EMPTY_FLAG_N,
    output logic COMPOSITE_FULL_N,
    output logic COMPOSITE_EMPTY_N,
    output logic FLAG_OE_N,
    output logic SERIAL_PORT_ENABLE,
    output logic TEST_PORT_ENABLE,
    output mqfep_pkg::mqfep_power_e POWER_STATE
);
    import mqfep_pkg::*;

    function automatic logic [`MQFEP_QUEUES-1:0] qdecode(input logic [`MQFEP_QSEL_W-1:0] sel);
        qdecode = `MQFEP_QUEUES'(1) << sel;
    endfunction

    // power-down pin synchroniser and power state
    logic pd_meta_reg, pd_meta_next, pd_sync_reg, pd_sync_next;
    mqfep_power_e pw_state_reg, pw_state_next;
    logic [`MQFEP_WAKE_W-1:0] wake_cnt_reg, wake_cnt_next;
    logic port_en_reg, port_en_next;
    logic run, in_wake;

    // configuration and pipelines
    logic fall_through_mode_reg, fall_through_mode_next, x20_reg, x20_next;
    logic wreq_reg, wreq_next;
    logic [`MQFEP_QSEL_W-1:0] wsel_reg, wsel_next, rsel_reg, rsel_next;
    logic [`MQFEP_DATA_W-1:0] wdata_reg, wdata_next;

    // output register and read side
    logic [`MQFEP_DATA_W-1:0] word_reg, word_next, dout_reg, dout_next;
    logic out_valid_reg, out_valid_next, half_pend_reg, half_pend_next;
    logic echo_reg, echo_next;
    logic [1:0] oe_n_reg, oe_n_next;
    logic flag_oe_n_reg, flag_oe_n_next;
    logic [`MQFEP_QUEUES-1:0] full_n_reg, full_n_next, empty_n_reg, empty_n_next;
    logic [`MQFEP_QUEUES-1:0] af_n_reg, af_n_next, ae_n_reg, ae_n_next;
    logic cfull_n_reg, cfull_n_next, cempty_n_reg, cempty_n_next;
    logic rd_req, has_sel, pop, load, half_step, drive;
    logic rd_sel_has, wr_sel_ready;

    // queue array
    logic [`MQFEP_QUEUES-1:0] q_push, q_ready, q_valid, q_pop;
    logic [`MQFEP_DATA_W-1:0] q_data [`MQFEP_QUEUES];
    logic [`MQFEP_LVL_W-1:0] q_level [`MQFEP_QUEUES];

    genvar gq;
    generate
        for (gq = 0; gq < `MQFEP_QUEUES; gq++) begin : g_queue
            mqfep_fifo #(
                .WIDTH(`MQFEP_DATA_W),
                .DEPTH(`MQFEP_DEPTH),
                .AW(`MQFEP_AW)
            ) u_fifo (
                .clk(CLK),
                .rst(RST),
                .in_valid(q_push[gq]),
                .in_ready(q_ready[gq]),
                .in_data(wdata_reg),
                .out_valid(q_valid[gq]),
                .out_ready(q_pop[gq]),
                .out_data(q_data[gq]),
                .level(q_level[gq])
            );
        end
    endgenerate

    assign run = pw_state_reg == MQFEP_PW_RUN;
    assign in_wake = pw_state_reg == MQFEP_PW_WAKE;
    assign rd_sel_has = q_valid[READ_QUEUE_SELECT];
    assign wr_sel_ready = q_ready[WRITE_QUEUE_SELECT];
    // a write lands in its queue one clock after the pins are sampled
    assign q_push = (wreq_reg && run) ? qdecode(wsel_reg) : '0;
    assign q_pop = pop ? qdecode(rsel_reg) : '0;

    // power sequencing
    always_comb begin
        pd_meta_next = !POWER_DOWN_N;
        pd_sync_next = pd_meta_reg;
        pw_state_next = pw_state_reg;
        wake_cnt_next = wake_cnt_reg;
        unique case (pw_state_reg)
            MQFEP_PW_RUN: begin
                if (pd_sync_reg) begin
                    pw_state_next = MQFEP_PW_DOWN;
                end
            end
            MQFEP_PW_DOWN: begin
                if (!pd_sync_reg) begin
                    pw_state_next = MQFEP_PW_WAKE;
                    wake_cnt_next = '0;
                end
            end
            MQFEP_PW_WAKE: begin
                if (pd_sync_reg) begin
                    pw_state_next = MQFEP_PW_DOWN;
                end else if (wake_cnt_reg == `MQFEP_WAKE_LAST) begin
                    pw_state_next = MQFEP_PW_RUN;
                end else begin
                    wake_cnt_next = wake_cnt_reg + 1'b1;
                end
            end
            default: pw_state_next = MQFEP_PW_DOWN;
        endcase
        port_en_next = pw_state_next == MQFEP_PW_RUN;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pd_meta_reg <= 1'b0;
            pd_sync_reg <= 1'b0;
            pw_state_reg <= MQFEP_PW_RUN;
            wake_cnt_reg <= '0;
            port_en_reg <= 1'b1;
        end else begin
            pd_meta_reg <= pd_meta_next;
            pd_sync_reg <= pd_sync_next;
            pw_state_reg <= pw_state_next;
            wake_cnt_reg <= wake_cnt_next;
            port_en_reg <= port_en_next;
        end
    end

    // queues, output register and flags held while not running; echo strobe and output enables forced off
    always_comb begin
        fall_through_mode_next = run ? FALL_THROUGH_MODE : fall_through_mode_reg;
        x20_next = run ? OUTPUT_WIDTH_SELECT : x20_reg;
        wreq_next = run && !WRITE_PORT_SELECT_N && !WRITE_ENABLE_N;
        wsel_next = WRITE_QUEUE_SELECT;
        wdata_next = DATA_IN;
        rsel_next = run ? READ_QUEUE_SELECT : rsel_reg;
        rd_req = run && !READ_PORT_SELECT_N && !READ_ENABLE_N;
        has_sel = q_valid[rsel_reg];
        pop = 1'b0;
        load = 1'b0;
        half_step = 1'b0;
        out_valid_next = out_valid_reg;
        if (fall_through_mode_reg) begin
            if (out_valid_reg) begin
                if (rd_req && half_pend_reg) begin
                    half_step = 1'b1;
                end else if (rd_req && has_sel) begin
                    pop = 1'b1;
                    load = 1'b1;
                end else if (rd_req) begin
                    out_valid_next = 1'b0;
                end
            end else if (run && has_sel) begin
                // falls through regardless of port select
                pop = 1'b1;
                load = 1'b1;
                out_valid_next = 1'b1;
            end
        end else if (rd_req && half_pend_reg) begin
            half_step = 1'b1;
        end else if (rd_req && has_sel) begin
            pop = 1'b1;
            load = 1'b1;
            out_valid_next = 1'b1;
        end
        word_next = load ? q_data[rsel_reg] : word_reg;
        half_pend_next = load ? x20_reg : (half_step ? 1'b0 : half_pend_reg);
        // pending upper half means the lower half is on the pins
        dout_next = word_next;
        if (x20_reg && !half_pend_next) begin
            dout_next[`MQFEP_HALF_W-1:0] = word_next[`MQFEP_DATA_W-1:`MQFEP_HALF_W];
        end
        echo_next = run ? !(load || half_step) : 1'b1;
        drive = run && !READ_PORT_SELECT_N && !OUTPUT_DRIVE_N;
        oe_n_next = {!(drive && !x20_reg), !drive};
        flag_oe_n_next = !run;
        full_n_next = full_n_reg;
        empty_n_next = empty_n_reg;
        af_n_next = af_n_reg;
        ae_n_next = ae_n_reg;
        cfull_n_next = cfull_n_reg;
        cempty_n_next = cempty_n_reg;
        if (run) begin
            for (int q = 0; q < `MQFEP_QUEUES; q++) begin
                full_n_next[q] = fall_through_mode_reg ^ q_ready[q];
                empty_n_next[q] = fall_through_mode_reg ^ q_valid[q];
                af_n_next[q] = !(q_level[q] >= `MQFEP_AF_LEVEL);
                ae_n_next[q] = !(q_level[q] <= `MQFEP_AE_LEVEL);
            end
            cfull_n_next = fall_through_mode_reg ^ wr_sel_ready;
            // fall-through ready tracks the output register, fed from the delayed select
            cempty_n_next = fall_through_mode_reg ? !out_valid_next : rd_sel_has;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            fall_through_mode_reg <= 1'b0;
            x20_reg <= 1'b0;
            wreq_reg <= 1'b0;
            wsel_reg <= '0;
            wdata_reg <= '0;
            rsel_reg <= '0;
            word_reg <= '0;
            dout_reg <= '0;
            out_valid_reg <= 1'b0;
            half_pend_reg <= 1'b0;
            echo_reg <= 1'b1;
            oe_n_reg <= `MQFEP_OE_OFF;
            flag_oe_n_reg <= 1'b0;
            full_n_reg <= '1;
            empty_n_reg <= '0;
            af_n_reg <= '1;
            ae_n_reg <= '0;
            cfull_n_reg <= 1'b1;
            cempty_n_reg <= 1'b0;
        end else begin
            fall_through_mode_reg <= fall_through_mode_next;
            x20_reg <= x20_next;
            wreq_reg <= wreq_next;
            wsel_reg <= wsel_next;
            wdata_reg <= wdata_next;
            rsel_reg <= rsel_next;
            word_reg <= word_next;
            dout_reg <= dout_next;
            out_valid_reg <= out_valid_next;
            half_pend_reg <= half_pend_next;
            echo_reg <= echo_next;
            oe_n_reg <= oe_n_next;
            flag_oe_n_reg <= flag_oe_n_next;
            full_n_reg <= full_n_next;
            empty_n_reg <= empty_n_next;
            af_n_reg <= af_n_next;
            ae_n_reg <= ae_n_next;
            cfull_n_reg <= cfull_n_next;
            cempty_n_reg <= cempty_n_next;
        end
    end

    assign DATA_OUT = dout_reg;
    assign DATA_OE_N = oe_n_reg;
    assign ECHO_READ_STROBE_N = echo_reg;
    assign FULL_FLAG_N = full_n_reg;
    assign EMPTY_FLAG_N = empty_n_reg;
    assign ALMOST_FULL_FLAG_N = af_n_reg;
    assign ALMOST_EMPTY_FLAG_N = ae_n_reg;
    assign COMPOSITE_FULL_N = cfull_n_reg;
    assign COMPOSITE_EMPTY_N = cempty_n_reg;
    assign FLAG_OE_N = flag_oe_n_reg;
    assign SERIAL_PORT_ENABLE = port_en_reg;
    assign TEST_PORT_ENABLE = port_en_reg;
    assign POWER_STATE = pw_state_reg;

    AST_CEF_FOLLOWS: assert property (@(posedge CLK) disable iff (RST)
        run && !fall_through_mode_reg |=> COMPOSITE_EMPTY_N == $past(rd_sel_has))
        else $error("composite empty did not follow read queue");
    AST_CFULL_FOLLOWS: assert property (@(posedge CLK) disable iff (RST)
        run |=> COMPOSITE_FULL_N == ($past(fall_through_mode_reg) ^ $past(wr_sel_ready)))
        else $error("composite full did not follow write queue");
    AST_ECHO_READ: assert property (@(posedge CLK) disable iff (RST)
        run && !fall_through_mode_reg && !READ_PORT_SELECT_N && !READ_ENABLE_N && (has_sel || half_pend_reg)
        |=> !ECHO_READ_STROBE_N)
        else $error("echo strobe missed a standard read");
    AST_ECHO_IDLE: assert property (@(posedge CLK) disable iff (RST)
        !fall_through_mode_reg && READ_PORT_SELECT_N |=> ECHO_READ_STROBE_N)
        else $error("echo strobe low without port select");
    AST_FALL_IN: assert property (@(posedge CLK) disable iff (RST)
        run && fall_through_mode_reg && !out_valid_reg && has_sel |=> !ECHO_READ_STROBE_N && !COMPOSITE_EMPTY_N)
        else $error("fall-through word not signalled");
    AST_LAST_READ: assert property (@(posedge CLK) disable iff (RST)
        rd_req && fall_through_mode_reg && out_valid_reg && !half_pend_reg && !has_sel
        |=> ECHO_READ_STROBE_N && COMPOSITE_EMPTY_N)
        else $error("read past last word not flagged");
    AST_DRIVE: assert property (@(posedge CLK) disable iff (RST)
        !DATA_OE_N[0] |-> !$past(READ_PORT_SELECT_N) && !$past(OUTPUT_DRIVE_N))
        else $error("data bus driven without select");
    AST_UPPER_Z: assert property (@(posedge CLK) disable iff (RST)
        $past(x20_reg) |-> DATA_OE_N[1])
        else $error("upper data bits driven in narrow mode");
    AST_PD_HIZ: assert property (@(posedge CLK) disable iff (RST)
        !run |=> FLAG_OE_N && DATA_OE_N == `MQFEP_OE_OFF)
        else $error("outputs driven while powered down");
    AST_PD_HOLD: assert property (@(posedge CLK) disable iff (RST)
        !run && $past(!run) |-> $stable(FULL_FLAG_N) && $stable(COMPOSITE_EMPTY_N) && $stable(fall_through_mode_reg))
        else $error("state changed while powered down");
    AST_PORTS_OFF: assert property (@(posedge CLK) disable iff (RST)
        !run |-> !SERIAL_PORT_ENABLE && !TEST_PORT_ENABLE)
        else $error("programming ports active while powered down");
    AST_WAKE_END: assert property (@(posedge CLK) disable iff (RST)
        in_wake && !pd_sync_reg && wake_cnt_reg == `MQFEP_WAKE_LAST |=> run)
        else $error("wake wait did not end on time");
endmodule

//--- mqfep_params.svh
// constants for the four-queue flow-control buffer control block
// assumes a single 100 MHz clock shared by the write and read sides
`ifndef MQFEP_PARAMS_SVH
`define MQFEP_PARAMS_SVH

`define MQFEP_QUEUES 4
`define MQFEP_QSEL_W 2
`define MQFEP_DATA_W 40
`define MQFEP_HALF_W 20
`define MQFEP_DEPTH 8
`define MQFEP_AW 3
`define MQFEP_LVL_W 4
`define MQFEP_AF_LEVEL 4'h7
`define MQFEP_AE_LEVEL 4'h1
`define MQFEP_OE_OFF 2'h3
`define MQFEP_WAKE_NS 1000
`define MQFEP_CLK_NS 10
`define MQFEP_WAKE_CYC ((`MQFEP_WAKE_NS + `MQFEP_CLK_NS - 1) / `MQFEP_CLK_NS)
`define MQFEP_WAKE_W 7
`define MQFEP_WAKE_LAST 7'(`MQFEP_WAKE_CYC - 1)

`endif

//--- mqfep_pkg.sv
// types for the four-queue flow-control buffer control block
// assumes mqfep_params.svh is on the include path
package mqfep_pkg;
    typedef enum logic [1:0] {
        MQFEP_PW_RUN = 2'b00,
        MQFEP_PW_DOWN = 2'b01,
        MQFEP_PW_WAKE = 2'b10
    } mqfep_power_e;
endpackage

//--- mqfep_fifo.sv
// one queue: flip-flop FIFO with valid/ready on both sides
// assumes DEPTH is a power of two so pointers wrap naturally
module mqfep_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem_reg[rp_reg];
    assign level = cnt_reg;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        mem_next = mem_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wp_reg] = in_data;
            wp_next = wp_reg + 1'b1;
        end
        if (pop) begin
            rp_next = rp_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    // storage needs no reset, only the pointers and count do
    always_ff @(posedge clk) begin
        mem_reg <= mem_next;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

//--- mqfep_host.sv
// host model: write-side and read-side controllers for the four-queue buffer
// assumes one clock for both sides; pins move by non-blocking assignment at the rising edge
`include "mqfep_params.svh"
module mqfep_host (
    input wire logic clk,
    output logic wps_n,
    output logic wen_n,
    output logic [`MQFEP_QSEL_W-1:0] wqs,
    output logic [`MQFEP_DATA_W-1:0] din,
    output logic rps_n,
    output logic ren_n,
    output logic [`MQFEP_QSEL_W-1:0] rqs,
    output logic pd_n
);
    initial begin
        {wps_n, wen_n, rps_n, ren_n, pd_n} = 5'h0F;
        {wqs, rqs} = 4'h0;
        din = 40'h0;
    end
    // idle data bus carries the inverse so a stale word never passes for a new one
    task automatic wr(input logic en_n, input logic [1:0] q, input logic [39:0] d);
        @(posedge clk);
        wen_n <= en_n;
        wqs <= q;
        din <= en_n ? ~din : d;
    endtask
    // write port select moves on its own edge, apart from any write enable
    task automatic wport(input logic sel_n);
        @(posedge clk);
        wps_n <= sel_n;
    endtask
    task automatic rd(input logic en_n);
        @(posedge clk);
        ren_n <= en_n;
    endtask
    // callers move port select here, at least a cycle before any read enable
    task automatic rsel(input logic [1:0] q, input logic sel_n);
        @(posedge clk);
        rqs <= q;
        rps_n <= sel_n;
    endtask
    task automatic pwr(input logic up);
        if (!up) repeat (4) @(posedge clk);
        @(posedge clk);
        pd_n <= up;
    endtask
endmodule

//--- tb_top.sv
// self-checking bench for the four-queue buffer control block
// assumes mqfep_host drives the host pins; reset, modes and output drive come from here
`include "mqfep_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mqfep_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ft = 1'b0;
    logic ow = 1'b0;
    logic od_n = 1'b0;
    logic wps_n, wen_n, rps_n, ren_n, pd_n, echo_n, cfull_n, cempty_n, flag_oe_n, sp_en, tp_en;
    logic [1:0] wqs, rqs, oe_n;
    logic [39:0] din, dout;
    logic [3:0] full_n, empty_n, afull_n, aempty_n;
    mqfep_power_e pstate;
    int bad_count = 0;
    int n_compared = 0;
    mqfep_top i_dut (
        .CLK(clk), .RST(rst), .WRITE_PORT_SELECT_N(wps_n), .WRITE_ENABLE_N(wen_n),
        .WRITE_QUEUE_SELECT(wqs), .DATA_IN(din), .READ_PORT_SELECT_N(rps_n), .READ_ENABLE_N(ren_n),
        .READ_QUEUE_SELECT(rqs), .OUTPUT_DRIVE_N(od_n), .FALL_THROUGH_MODE(ft), .OUTPUT_WIDTH_SELECT(ow),
        .POWER_DOWN_N(pd_n), .DATA_OUT(dout), .DATA_OE_N(oe_n), .ECHO_READ_STROBE_N(echo_n),
        .FULL_FLAG_N(full_n), .EMPTY_FLAG_N(empty_n), .ALMOST_FULL_FLAG_N(afull_n),
        .ALMOST_EMPTY_FLAG_N(aempty_n), .COMPOSITE_FULL_N(cfull_n), .COMPOSITE_EMPTY_N(cempty_n),
        .FLAG_OE_N(flag_oe_n), .SERIAL_PORT_ENABLE(sp_en), .TEST_PORT_ENABLE(tp_en), .POWER_STATE(pstate)
    );
    mqfep_host i_host (
        .clk(clk), .wps_n(wps_n), .wen_n(wen_n), .wqs(wqs), .din(din),
        .rps_n(rps_n), .ren_n(ren_n), .rqs(rqs), .pd_n(pd_n)
    );
    // settle past the edge so registered outputs are read, never raced
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic done(input string name);
        $display("test %s finished at %0t", name, $time);
    endtask
    task automatic do_reset(input logic ft_v, input logic ow_v);
        @(posedge clk);
        rst <= 1'b1;
        {ft, ow} <= {ft_v, ow_v};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(1);
    endtask
    task automatic t_queues();
        for (int q = 0; q < 4; q++) i_host.wr(1'b0, 2'(q), 40'hC0FFEE0000 + 40'(q));
        i_host.wr(1'b1, 2'h0, 40'h0);
        tick(3);
        check(empty_n, 4'hF);
        check(aempty_n, 4'h0);
        for (int q = 3; q >= 0; q--) begin
            i_host.rsel(2'(q), 1'b0);
            i_host.rd(1'b0);
            i_host.rd(1'b1);
            tick(0);
            check(dout, 40'hC0FFEE0000 + 40'(q));
            check(echo_n, 1'b0);
            check(oe_n, 2'h0);
        end
        i_host.rd(1'b0);
        i_host.rd(1'b1);
        tick(0);
        check(echo_n, 1'b1);
        done("queues");
    endtask
    task automatic t_full();
        for (int i = 0; i < 9; i++) i_host.wr(1'b0, 2'h2, 40'h5A00000000 + 40'(i));
        i_host.wr(1'b1, 2'h2, 40'h0);
        tick(3);
        check({full_n[2], afull_n[2], aempty_n[2], cfull_n}, 4'h2);
        i_host.wr(1'b1, 2'h0, 40'h0);
        tick(0);
        check(cfull_n, 1'b0);
        tick(1);
        check(cfull_n, 1'b1);
        i_host.rsel(2'h2, 1'b0);
        tick(0);
        check(cempty_n, 1'b0);
        tick(1);
        check(cempty_n, 1'b1);
        i_host.rd(1'b0);
        for (int i = 0; i < 8; i++) begin
            i_host.rd(i == 7);
            tick(0);
            check(dout, 40'h5A00000000 + 40'(i));
            if (i == 1) check(full_n[2], 1'b1);
        end
        tick(2);
        check({empty_n[2], aempty_n[2]}, 2'h0);
        done("full");
    endtask
    task automatic t_half();
        do_reset(1'b0, 1'b1);
        i_host.wr(1'b0, 2'h1, 40'hABCDE12345);
        i_host.wr(1'b1, 2'h1, 40'h0);
        i_host.rsel(2'h1, 1'b0);
        i_host.rd(1'b0);
        i_host.rd(1'b0);
        tick(0);
        check(dout[19:0], 20'h12345);
        check(oe_n, 2'h2);
        i_host.rd(1'b1);
        tick(0);
        check(dout[19:0], 20'hABCDE);
        check(echo_n, 1'b0);
        // write without port select must be ignored
        i_host.wport(1'b1);
        i_host.wr(1'b0, 2'h0, 40'h1111111111);
        i_host.wr(1'b1, 2'h0, 40'h0);
        i_host.wport(1'b0);
        tick(2);
        check(empty_n[0], 1'b0);
        done("half");
    endtask
    task automatic t_ft();
        do_reset(1'b1, 1'b0);
        i_host.rsel(2'h0, 1'b1);
        i_host.wr(1'b0, 2'h0, 40'h0FEEDBEEF0);
        i_host.wr(1'b1, 2'h0, 40'h0);
        for (int i = 0; i < 6 && echo_n !== 1'b0; i++) tick(1);
        check(echo_n, 1'b0);
        check({cempty_n, oe_n}, 3'h3);
        i_host.rsel(2'h0, 1'b0);
        tick(2);
        check(oe_n, 2'h0);
        check(dout, 40'h0FEEDBEEF0);
        @(posedge clk);
        od_n <= 1'b1;
        tick(1);
        check(oe_n, 2'h3);
        @(posedge clk);
        od_n <= 1'b0;
        i_host.rd(1'b0);
        i_host.rd(1'b1);
        tick(0);
        check({cempty_n, echo_n}, 2'h3);
        // unselected queue fills; output ready follows only after the select moves
        i_host.wr(1'b0, 2'h2, 40'h2222222222);
        i_host.wr(1'b1, 2'h2, 40'h0);
        tick(3);
        check(cempty_n, 1'b1);
        i_host.rsel(2'h2, 1'b0);
        tick(1);
        check(cempty_n, 1'b1);
        tick(1);
        check({cempty_n, echo_n}, 2'h0);
        check(dout, 40'h2222222222);
        done("fall-through");
    endtask
    task automatic t_power();
        logic [3:0] held;
        int n;
        i_host.wr(1'b0, 2'h3, 40'h3333333333);
        i_host.wr(1'b1, 2'h3, 40'h0);
        tick(3);
        held = empty_n;
        i_host.pwr(1'b0);
        for (n = 0; n < 6 && pstate !== MQFEP_PW_DOWN; n++) tick(1);
        tick(1);
        check({flag_oe_n, oe_n}, 3'h7);
        check({sp_en, tp_en}, 2'h0);
        check(empty_n, held);
        i_host.pwr(1'b1);
        for (n = 0; n < 200 && pstate !== MQFEP_PW_RUN; n++) tick(1);
        check(n >= `MQFEP_WAKE_CYC, 1'b1);
        check(pstate, MQFEP_PW_RUN);
        tick(2);
        check(flag_oe_n, 1'b0);
        done("power");
    endtask
    task automatic print_verdict();
        $display("%0d compared, %0d mismatched", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // free-running clock: flags only move while it runs
    initial forever #5 clk = ~clk;
    initial begin
        #50000;
        bad_count++;
        print_verdict();
    end
    initial begin
        do_reset(1'b0, 1'b0);
        check({full_n, empty_n, afull_n, aempty_n, cfull_n, cempty_n, oe_n, echo_n, flag_oe_n}, 22'h3C3C2E);
        check(pstate, MQFEP_PW_RUN);
        done("reset");
        t_queues();
        t_full();
        t_half();
        t_ft();
        t_power();
        print_verdict();
    end
endmodule
